/* design/l2sync_pkg.sv */
// Shared constants for the second-level cache synchronize controller.
// Assumes a single 200 MHz clock domain; no software-visible registers.
package l2sync_pkg;
   // ==========================================================
   // Geometry defaults
   localparam int L2SYNC_SETS_DEF = 16;   // Tag sets walked per synchronize
   localparam int L2SYNC_WAYS_DEF = 2;    // Ways per set
   // ==========================================================
   // Line state encoding (MESI)
   typedef enum logic [1:0]
   {
      L2SYNC_ST_I = 2'h0,  // Invalid
      L2SYNC_ST_S = 2'h1,  // Shared
      L2SYNC_ST_E = 2'h2,  // Exclusive, clean
      L2SYNC_ST_M = 2'h3   // Modified
   } l2sync_line_t;
   // ==========================================================
   // Reset values
   localparam logic L2SYNC_POLICY_RST = 1'b0;  // Write-through until first fill decision
   // Line policy levels driven to the processor
   localparam logic L2SYNC_POL_WB = 1'b1;
   localparam logic L2SYNC_POL_WT = 1'b0;
endpackage : l2sync_pkg

/* design/l2sync_tag_array.sv */
// Tag state array for the synchronize controller: one state per set and way.
// Assumes the controller is the only writer; reads are combinational.
`timescale 1ns/1ps
`default_nettype none
module l2sync_tag_array
   import l2sync_pkg::*;
#(
   parameter int SETS = L2SYNC_SETS_DEF,
   parameter int WAYS = L2SYNC_WAYS_DEF,
   parameter int SW   = $clog2(SETS),
   parameter int WW   = (WAYS > 1) ? $clog2(WAYS) : 1
)
(
   input  wire logic          mclk,
   input  wire logic          arst_n,
   input  wire logic          wr_en,    // Write one state entry
   input  wire logic [SW-1:0] wr_set,   // Set written
   input  wire logic [WW-1:0] wr_way,   // Way written
   input  wire l2sync_line_t  wr_state, // New state
   input  wire logic [SW-1:0] rd_set,   // Set read
   input  wire logic [WW-1:0] rd_way,   // Way read
   output l2sync_line_t       rd_state  // State of read entry
);
   // ==========================================================
   // Storage
   l2sync_line_t mem [SETS][WAYS];  // Line states, all invalid after reset

   // Combinational read port
   assign rd_state = mem[rd_set][rd_way];

   // ==========================================================
   // Write port
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int s = 0; s < SETS; s++)
         begin
            for (int w = 0; w < WAYS; w++)
            begin
               mem[s][w] <= L2SYNC_ST_I;
            end
         end
      end
      else if (wr_en)
      begin
         mem[wr_set][wr_way] <= wr_state;
      end
   end
endmodule : l2sync_tag_array
`default_nettype wire

/* design/l2sync_ctrl.sv */
// Second-level cache synchronize controller: walks the tag array on request,
// inquires the processor for each modified line, writes it to memory, marks
// it exclusive. Also drives line policy and way indication per fill.
// Assumes processor and memory bus handshakes are synchronous to mclk.
// Behaviour
// - Synchronize writes back every modified line
// - Synchronize never invalidates any tag
// - E, I, S lines keep their state
// - Inquire processor before memory writeback
// - Written-back line becomes exclusive
// - Sync pin doubles as latch-drive strap
// - Line policy driven per line fill
// - Policy keeps shared fills in writethrough
// - Way indication driven to cache SRAM
`timescale 1ns/1ps
`default_nettype none
module l2sync_ctrl
   import l2sync_pkg::*;
#(
   parameter int SETS = L2SYNC_SETS_DEF,
   parameter int WAYS = L2SYNC_WAYS_DEF,
   parameter int SW   = $clog2(SETS),
   parameter int WW   = (WAYS > 1) ? $clog2(WAYS) : 1
)
(
   input  wire logic          mclk,
   input  wire logic          arst_n,
   input  wire logic          sync_req_n,           // Shared pin: sync request / strap
   output logic               addr_latch_drive_cfg, // Strap captured after reset
   input  wire logic          cycle_addr_strobe_n,  // Processor cycle start
   input  wire logic          cpu_wr,               // Write/read, valid with strobe
   input  wire logic          fill_req,             // Line fill pulse from lookup
   input  wire logic [SW-1:0] fill_set,             // Set filled or written
   input  wire logic [WW-1:0] fill_way,             // Way filled or written
   input  wire logic          fill_shared,          // Line also held elsewhere
   output logic               line_policy_sel,      // Writeback high, writethrough low
   output logic [WW-1:0]      way_sel,              // Way indication to SRAM
   output logic               sram_way_valid,       // Way indication qualifier
   output logic               inq_req,              // Inquire to processor
   output logic [SW-1:0]      inq_set,              // Set inquired
   input  wire logic          inq_done,             // Processor writeback finished
   output logic               mem_wb_req,           // Memory writeback request
   output logic [SW-1:0]      mem_wb_set,           // Set written to memory
   input  wire logic          mem_wb_done,          // Memory bus accepted line
   output logic               cpu_hold,             // Hold off new processor cycles
   output logic               sync_busy,            // Synchronize in progress
   output logic               cpu_wr_cycle          // Registered write cycle flag
);
   // ==========================================================
   // Walk state machine
   typedef enum logic [4:0]
   {
      L2SYNC_IDLE  = 5'h01,  // Waiting for request
      L2SYNC_LOOK  = 5'h02,  // Examine current entry
      L2SYNC_INQ   = 5'h04,  // Inquiring processor
      L2SYNC_WB    = 5'h08,  // Memory writeback
      L2SYNC_NEXT  = 5'h10   // Advance pointer
   } l2sync_state_t;

   l2sync_state_t state;        // Current walk state
   logic [SW-1:0] walk_set;     // Set pointer
   logic [WW-1:0] walk_way;     // Way pointer
   logic          strap_done;   // Strap already captured
   logic          sync_seen;    // Sync request seen (level, low active, not registered)
   l2sync_line_t  rd_state;     // Entry under walk
   logic          tag_wr;       // Tag write strobe
   logic [SW-1:0] tag_wset;     // Tag write set
   logic [WW-1:0] tag_wway;     // Tag write way
   l2sync_line_t  tag_wst;      // Tag write state
   logic          last_entry;   // Pointer at final entry
   logic [SW-1:0] rd_set_sel;   // Tag read set: lookup when idle, walk otherwise
   logic [WW-1:0] rd_way_sel;   // Tag read way: lookup when idle, walk otherwise

   assign last_entry = (walk_set == SW'(SETS - 1)) && (walk_way == WW'(WAYS - 1));

   // Idle reads serve processor write lookups; the walk owns the port otherwise
   assign rd_set_sel = (state == L2SYNC_IDLE) ? fill_set : walk_set;
   assign rd_way_sel = (state == L2SYNC_IDLE) ? fill_way : walk_way;

   // ==========================================================
   // Strap capture
   // The shared pin is read as a strap in the first cycle after reset
   // release; only afterwards does it count as a synchronize request.
   // strap then request
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         strap_done           <= 1'b0;
         addr_latch_drive_cfg <= 1'b0;
      end
      else if (!strap_done)
      begin
         strap_done           <= 1'b1;
         addr_latch_drive_cfg <= sync_req_n;
      end
   end

   assign sync_seen = strap_done && !sync_req_n;

   // ==========================================================
   // Tag array
   l2sync_tag_array #(
      .SETS (SETS),
      .WAYS (WAYS)
   ) u_tags (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .wr_en    (tag_wr),
      .wr_set   (tag_wset),
      .wr_way   (tag_wway),
      .wr_state (tag_wst),
      .rd_set   (rd_set_sel),
      .rd_way   (rd_way_sel),
      .rd_state (rd_state)
   );

   // ==========================================================
   // Tag writes: fills when idle, exclusive marking after writeback
   // Writeback completion only ever writes E; nothing here writes I.
   always_comb
   begin
      tag_wr   = 1'b0;
      tag_wset = fill_set;
      tag_wway = fill_way;
      tag_wst  = fill_shared ? L2SYNC_ST_S : L2SYNC_ST_E;
      if (state == L2SYNC_WB)
      begin
         tag_wr   = mem_wb_done;
         tag_wset = walk_set;
         tag_wway = walk_way;
         tag_wst  = L2SYNC_ST_E;
      end
      else if (state == L2SYNC_IDLE)
      begin
         tag_wr = fill_req;
         // write keeps modified data
         // Invalid entries are left alone; a fill in the same cycle wins
         if (!fill_req && !cycle_addr_strobe_n && cpu_wr && rd_state != L2SYNC_ST_I)
         begin
            tag_wr  = 1'b1;
            tag_wst = L2SYNC_ST_M;
         end
      end
   end

   // ==========================================================
   // Walk sequencing
   // walk all entries
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state    <= L2SYNC_IDLE;
         walk_set <= '0;
         walk_way <= '0;
      end
      else
      begin
         unique case (state)
            L2SYNC_IDLE:
            begin
               walk_set <= '0;
               walk_way <= '0;
               if (sync_seen)
               begin
                  state <= L2SYNC_LOOK;
               end
            end
            L2SYNC_LOOK:
            begin
               if (rd_state == L2SYNC_ST_M)
               begin
                  state <= L2SYNC_INQ;
               end
               else
               begin
                  state <= L2SYNC_NEXT;
               end
            end
            L2SYNC_INQ:
            begin
               if (inq_done)
               begin
                  state <= L2SYNC_WB;
               end
            end
            L2SYNC_WB:
            begin
               if (mem_wb_done)
               begin
                  state <= L2SYNC_NEXT;
               end
            end
            L2SYNC_NEXT:
            begin
               if (last_entry)
               begin
                  state <= L2SYNC_IDLE;
               end
               else
               begin
                  state <= L2SYNC_LOOK;
                  if (walk_way == WW'(WAYS - 1))
                  begin
                     walk_way <= '0;
                     walk_set <= walk_set + SW'(1);
                  end
                  else
                  begin
                     walk_way <= walk_way + WW'(1);
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Handshake outputs, combinational from state
   // inquire each modified line
   assign inq_req    = (state == L2SYNC_INQ);
   assign inq_set    = walk_set;
   assign mem_wb_req = (state == L2SYNC_WB);
   assign mem_wb_set = walk_set;
   assign sync_busy  = (state != L2SYNC_IDLE);
   assign cpu_hold   = sync_busy;

   // ==========================================================
   // Line policy and way indication, registered per fill
   // Writeback is granted only to exclusive fills; shared fills stay
   // writethrough so the processor's first write reaches this level.
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         line_policy_sel <= L2SYNC_POLICY_RST;
         way_sel         <= '0;
         sram_way_valid  <= 1'b0;
      end
      else
      begin
         sram_way_valid <= 1'b0;
         if (state == L2SYNC_IDLE && fill_req)
         begin
            line_policy_sel <= fill_shared ? L2SYNC_POL_WT : L2SYNC_POL_WB;
            way_sel         <= fill_way;
            sram_way_valid  <= 1'b1;
         end
         else if (state == L2SYNC_INQ || state == L2SYNC_WB)
         begin
            way_sel        <= walk_way;
            sram_way_valid <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Cycle type capture
   // sample write/read with strobe
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cpu_wr_cycle <= 1'b0;
      end
      else if (!cycle_addr_strobe_n)
      begin
         cpu_wr_cycle <= cpu_wr;
      end
   end
endmodule : l2sync_ctrl
`default_nettype wire

/* tb/l2sync_ctrl_chk.sv */
// Port checker for the synchronize controller.
// Assumes one mclk domain; walk length allows for inquiry and writeback waits.
`timescale 1ns/1ps
`default_nettype none
module l2sync_ctrl_chk
   import l2sync_pkg::*;
#(
   parameter int SETS = L2SYNC_SETS_DEF,
   parameter int WAYS = L2SYNC_WAYS_DEF,
   parameter int WW   = (WAYS > 1) ? $clog2(WAYS) : 1
)
(
   input wire logic          mclk,
   input wire logic          arst_n,
   input wire logic          sync_req_n,
   input wire logic          addr_latch_drive_cfg,
   input wire logic          cycle_addr_strobe_n,
   input wire logic          cpu_wr,
   input wire logic          cpu_wr_cycle,
   input wire logic          fill_req,
   input wire logic [WW-1:0] fill_way,
   input wire logic          fill_shared,
   input wire logic          line_policy_sel,
   input wire logic [WW-1:0] way_sel,
   input wire logic          sram_way_valid,
   input wire logic          inq_req,
   input wire logic          inq_done,
   input wire logic          mem_wb_req,
   input wire logic          mem_wb_done,
   input wire logic          cpu_hold,
   input wire logic          sync_busy
);
   // ==========================================================
   // Helper logic
   logic strap_done;  // High from the first edge after reset
   int   busy_cnt;    // Cycles the current walk has lasted
   int   wait_cnt;    // Walk cycles spent on inquiry or writeback
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Strap window and walk length; waits on the far side are counted apart
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         strap_done <= 1'b0;
         busy_cnt   <= 0;
         wait_cnt   <= 0;
      end
      else
      begin
         strap_done <= 1'b1;
         busy_cnt   <= sync_busy ? busy_cnt + 1 : 0;
         wait_cnt   <= sync_busy ? wait_cnt + int'(inq_req || mem_wb_req) : 0;
      end
   end
   // ==========================================================
   // Assertions
   strap_take_a: assert property (!strap_done |=> addr_latch_drive_cfg == $past(sync_req_n))
      else $error("strap not captured");
   strap_keep_a: assert property (strap_done |=> $stable(addr_latch_drive_cfg))
      else $error("strap changed");
   policy_fill_a: assert property (fill_req && sync_req_n && !sync_busy |=>
      line_policy_sel == !$past(fill_shared) && sram_way_valid) else $error("policy wrong");
   way_fill_a: assert property (fill_req && sync_req_n && !sync_busy |=> way_sel == $past(fill_way))
      else $error("way wrong");
   way_pulse_a: assert property (sram_way_valid && !fill_req && !inq_req && !mem_wb_req |=> !sram_way_valid)
      else $error("way qualifier stuck");
   wr_capture_a: assert property (!cycle_addr_strobe_n |=> cpu_wr_cycle == $past(cpu_wr))
      else $error("write flag wrong");
   sync_start_a: assert property (strap_done && !sync_req_n && !sync_busy |=> sync_busy)
      else $error("sync not taken");
   hold_walk_a: assert property (cpu_hold == sync_busy)
      else $error("hold differs from busy");
   walk_len_a: assert property ($fell(sync_busy) |-> busy_cnt == 2 * SETS * WAYS + wait_cnt)
      else $error("walk length wrong");
   inq_stand_a: assert property (inq_req && !inq_done |=> inq_req)
      else $error("inquire dropped");
   inq_then_wb_a: assert property (inq_req && inq_done |-> ##[1:2] mem_wb_req)
      else $error("no writeback after inquire");
   wb_stand_a: assert property (mem_wb_req && !mem_wb_done |=> mem_wb_req && !inq_req)
      else $error("writeback dropped");
   inq_wb_excl_a: assert property (!(inq_req && mem_wb_req))
      else $error("inquire and writeback together");
   way_inq_a: assert property (inq_req |=> sram_way_valid)
      else $error("no way indication for writeback");
endmodule : l2sync_ctrl_chk
bind l2sync_ctrl l2sync_ctrl_chk #(.SETS(SETS), .WAYS(WAYS)) u_chk (.mclk(mclk), .arst_n(arst_n),
   .sync_req_n(sync_req_n), .addr_latch_drive_cfg(addr_latch_drive_cfg), .cpu_wr(cpu_wr),
   .cycle_addr_strobe_n(cycle_addr_strobe_n), .cpu_wr_cycle(cpu_wr_cycle), .fill_req(fill_req),
   .fill_way(fill_way), .fill_shared(fill_shared), .line_policy_sel(line_policy_sel), .way_sel(way_sel),
   .sram_way_valid(sram_way_valid), .inq_req(inq_req), .inq_done(inq_done), .mem_wb_req(mem_wb_req),
   .mem_wb_done(mem_wb_done), .cpu_hold(cpu_hold), .sync_busy(sync_busy));
`default_nettype wire

/* tb/l2sync_host_model.sv */
// Processor and memory bus responder for inquire and writeback requests.
// Assumes requests stand until their done pulse is seen.
`timescale 1ns/1ps
`default_nettype none
module l2sync_host_model
#(
   parameter int DLY = 2  // Cycles before each answer
)
(
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic inq_req,
   input  wire logic mem_wb_req,
   output logic      inq_done,
   output logic      mem_wb_done
);
   int cnt;  // Wait before answering, a slow partner
   // processor writes back before the memory step
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt         <= 0;
         inq_done    <= 1'b0;
         mem_wb_done <= 1'b0;
      end
      else
      begin
         // Done is a one-cycle pulse so a new request is never answered early
         cnt         <= ((inq_req || mem_wb_req) && cnt < DLY) ? cnt + 1 : 0;
         inq_done    <= inq_req && cnt == DLY && !inq_done;
         mem_wb_done <= mem_wb_req && cnt == DLY && !mem_wb_done;
      end
   end
endmodule : l2sync_host_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the synchronize controller.
// Assumes the checker is bound and the host model answers inquiries.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import l2sync_pkg::*;
;
   localparam int SETS = 4;  // Short walk keeps the run brief
   localparam int WAYS = 2;
   logic       mclk = 1'b0, arst_n = 1'b0, sync_req_n = 1'b1, strobe_n = 1'b1, cpu_wr = 1'b0;
   logic       fill_req = 1'b0, fill_shared = 1'b0, fill_way = 1'b0;
   logic [1:0] fill_set = 2'h0;
   logic       cfg, pol, way, wvalid, inq, inq_done, wb, wb_done, hold, busy, wr_cyc;
   logic [1:0] iset, wset;
   int         n_fail = 0, check_count = 0;
   l2sync_ctrl #(.SETS(SETS), .WAYS(WAYS)) u_dut (.mclk(mclk), .arst_n(arst_n), .sync_req_n(sync_req_n),
      .addr_latch_drive_cfg(cfg), .cycle_addr_strobe_n(strobe_n), .cpu_wr(cpu_wr), .fill_req(fill_req),
      .fill_set(fill_set), .fill_way(fill_way), .fill_shared(fill_shared), .line_policy_sel(pol),
      .way_sel(way), .sram_way_valid(wvalid), .inq_req(inq), .inq_set(iset), .inq_done(inq_done),
      .mem_wb_req(wb), .mem_wb_set(wset), .mem_wb_done(wb_done), .cpu_hold(hold), .sync_busy(busy),
      .cpu_wr_cycle(wr_cyc));
   l2sync_host_model u_host (.mclk(mclk), .arst_n(arst_n), .inq_req(inq), .mem_wb_req(wb),
      .inq_done(inq_done), .mem_wb_done(wb_done));
   // 200 MHz clock
   initial
   begin
      forever #2.5 mclk = ~mclk;
   end
   task automatic tick;
      @(posedge mclk);
      #1;
   endtask : tick
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   // Reset with the strap level given; the pin returns high after the strap edge
   task automatic t_reset(input logic strap);
      arst_n     = 1'b0;
      sync_req_n = strap;
      repeat (4) tick();
      chk("busy at reset", 8'h0, {7'h0, busy});
      arst_n = 1'b1;
      tick();
      sync_req_n = 1'b1;
      chk("strap", {7'h0, strap}, {7'h0, cfg});
      // Let an edge pass so a following request is not set in this time step
      tick();
      $display("test reset strap %0b done", strap);
   endtask : t_reset
   task automatic t_fill(input logic shared, input logic w);
      fill_req    = 1'b1;
      fill_shared = shared;
      fill_way    = w;
      fill_set    = 2'h3;
      tick();
      fill_req = 1'b0;
      chk("policy", {7'h0, shared ? L2SYNC_POL_WT : L2SYNC_POL_WB}, {7'h0, pol});
      chk("way", {7'h0, w}, {7'h0, way});
      chk("way valid", 8'h1, {7'h0, wvalid});
      tick();
      chk("way valid end", 8'h0, {7'h0, wvalid});
      $display("test fill shared %0b done", shared);
   endtask : t_fill
   // write flag driven with the strobe; the entry addressed rides on the fill lines
   task automatic t_strobe(input logic w, input logic [1:0] s, input logic wy);
      strobe_n = 1'b0;
      cpu_wr   = w;
      fill_set = s;
      fill_way = wy;
      tick();
      strobe_n = 1'b1;
      cpu_wr   = ~w;
      chk("write flag", {7'h0, w}, {7'h0, wr_cyc});
      // Idle edge keeps back-to-back strobes apart
      tick();
      $display("test strobe done");
   endtask : t_strobe
   // Walk: fills refused, one inquiry and writeback per modified line, all entries visited
   // Only set 3 way 1 is ever dirtied, so any inquiry must name it
   task automatic t_sync(input int exp_m);
      int   n;
      int   inqs;
      int   wbs;
      int   waits;
      logic last_inq;
      logic last_wb;
      n        = 0;
      inqs     = 0;
      wbs      = 0;
      waits    = 0;
      last_inq = 1'b0;
      last_wb  = 1'b0;
      sync_req_n = 1'b0;
      tick();
      sync_req_n = 1'b1;
      fill_req   = 1'b1;
      chk("busy", 8'h1, {7'h0, busy});
      chk("hold", 8'h1, {7'h0, hold});
      tick();
      fill_req = 1'b0;
      chk("refused fill", 8'h0, {7'h0, wvalid});
      n = 1;
      while (busy !== 1'b0 && n < 200)
      begin
         inqs  += (inq === 1'b1 && last_inq !== 1'b1);
         wbs   += (wb === 1'b1 && last_wb !== 1'b1);
         waits += (inq === 1'b1 || wb === 1'b1);
         if (inq === 1'b1)
            chk("inquire set", 8'h3, {6'h0, iset});
         if (wb === 1'b1)
         begin
            chk("writeback set", 8'h3, {6'h0, wset});
            chk("writeback way", 8'h1, {7'h0, way});
            chk("writeback way valid", 8'h1, {7'h0, wvalid});
         end
         last_inq = inq;
         last_wb  = wb;
         n++;
         tick();
      end
      chk("walk end", 8'h0, {7'h0, busy});
      chk("walk cycles", 8'(2 * SETS * WAYS), 8'(n - waits));
      chk("inquiries", 8'(exp_m), 8'(inqs));
      chk("writebacks", 8'(exp_m), 8'(wbs));
      if (n >= 200)
         wrap_up();
      $display("test sync done");
   endtask : t_sync
   initial
   begin
      t_reset(1'b1);
      t_fill(1'b0, 1'b1);
      t_fill(1'b1, 1'b0);
      // Write to an invalid entry and a read leave every line clean
      t_strobe(1'b1, 2'h0, 1'b0);
      t_strobe(1'b0, 2'h3, 1'b1);
      t_sync(0);
      t_sync(0);
      t_fill(1'b0, 1'b0);
      // Dirty the exclusive line, then sync: it must come back clean but valid
      t_strobe(1'b1, 2'h3, 1'b1);
      t_sync(1);
      t_sync(0);
      t_strobe(1'b1, 2'h3, 1'b1);
      t_sync(1);
      // Reset invalidates all, so the same write dirties nothing
      t_reset(1'b0);
      t_strobe(1'b1, 2'h3, 1'b1);
      t_sync(0);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
